// ---- hw/cdslc_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module cdslc_sync #(
  parameter int W = 1
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // A change counts once stages two and three agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_r[i];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r <= '0;
    end else begin
      s1_r <= i_d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= q_nxt;
    end
  end

  assign o_q = q_r;
endmodule : cdslc_sync

// ---- hw/cdslc_top.sv ----
// Receive slip control and transmit codirectional line coder
//
// Functional notes
// - Octets enter at line rate, leave on local receive bit clock only
// - Slow local clock: a complete unread octet is overwritten, discarded
// - Fast local clock: previously delivered octet is sent again
// - Slips act on whole octets; violation alignment is untouched
// - Byte-inserted flag high while a repeated octet is output
// - Byte-deleted flag high when an octet was discarded
// - Each bit period is four unit intervals, one symbol each
// - A one is coded high, high, low, low
// - A zero is coded high, low, high, low
// - Consecutive blocks alternate polarity across the two rails
// - Eighth block repeats previous polarity, carrying the octet's last bit
// - Eight bits shift out on bit clock rises inside the slot envelope
// - Alarm request held high suppresses the octet violations
// - Octet alarm after eight successive missing violations
// - One octet buffer fills from line while another is read out
`timescale 1ns/100ps
module cdslc_top (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_local_receive_bit_clock,
  input wire logic i_rx_slot_env,
  input wire logic i_rx_bit_clk,
  input wire logic i_rx_bit_data,
  input wire logic i_rx_bit_viol,
  input wire logic i_tx_ui_clk,
  input wire logic i_transmit_alarm_request,
  input wire cdslc_pkg::cdslc_bus_req_t i_bus,
  output logic [31:0] o_rdata,
  output logic o_pcm_serial_output,
  output logic o_receive_byte_inserted_flag,
  output logic o_receive_byte_deleted_flag,
  output logic o_octet_alarm,
  output logic o_tx_pos_n,
  output logic o_tx_neg_n,
  output logic o_irq
);
  cdslc_pkg::cdslc_pins_t pins;
  cdslc_pkg::cdslc_pins_t pins_d_r;

  cdslc_sync #(
    .W($bits(cdslc_pkg::cdslc_pins_t))
  ) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_d({i_local_receive_bit_clock, i_rx_slot_env, i_rx_bit_clk,
          i_rx_bit_data, i_rx_bit_viol, i_tx_ui_clk,
          i_transmit_alarm_request}),
    .o_q(pins)
  );

  logic lclk_rise;
  logic slot_start;
  logic rx_rise;
  logic ui_tick;
  assign lclk_rise = pins.lclk & ~pins_d_r.lclk;
  assign slot_start = pins.slot_env & ~pins_d_r.slot_env;
  assign rx_rise = pins.rx_clk & ~pins_d_r.rx_clk;
  assign ui_tick = pins.ui_clk & ~pins_d_r.ui_clk;

  // Receive octet assembly on the recovered line clock
  logic [7:0] fill_r, fill_nxt;
  logic [2:0] rx_idx_r, rx_idx_nxt;
  logic [3:0] miss_r, miss_nxt;
  logic [7:0] hold_r, hold_nxt;
  logic ready_r, ready_nxt;
  logic del_pend_r, del_pend_nxt;
  logic complete;
  logic overwrite;

  always_comb begin
    fill_nxt = fill_r;
    rx_idx_nxt = rx_idx_r;
    miss_nxt = miss_r;
    complete = 1'b0;
    if (rx_rise) begin
      fill_nxt = {fill_r[6:0], pins.rx_data};
      if (pins.rx_viol) begin
        complete = 1'b1;
        rx_idx_nxt = 3'h0;
        miss_nxt = 4'h0;
      end else if (rx_idx_r == cdslc_pkg::LAST_BIT_IDX) begin
        complete = 1'b1;
        rx_idx_nxt = 3'h0;
        if (miss_r != cdslc_pkg::MISS_LIMIT_CNT) begin
          miss_nxt = miss_r + 4'h1;
        end
      end else begin
        rx_idx_nxt = rx_idx_r + 3'h1;
      end
    end
  end

  // Second buffer holds the completed octet until a slot takes it
  always_comb begin
    overwrite = complete & ready_r & ~slot_start;
    hold_nxt = complete ? fill_nxt : hold_r;
    ready_nxt = complete ? 1'b1 : (slot_start ? 1'b0 : ready_r);
    del_pend_nxt = overwrite | (del_pend_r & ~slot_start);
  end

  // Time-slot output side on the local clock
  logic [7:0] out_sr_r, out_sr_nxt;
  logic [7:0] last_r, last_nxt;
  logic [3:0] out_cnt_r, out_cnt_nxt;
  logic pcm_r, pcm_nxt;
  logic ins_r, ins_nxt;
  logic del_r, del_nxt;
  logic [7:0] src;

  always_comb begin
    src = out_sr_r;
    last_nxt = last_r;
    ins_nxt = ins_r;
    del_nxt = del_r;
    out_cnt_nxt = out_cnt_r;
    if (slot_start) begin
      if (ready_r) begin
        src = hold_r;
        last_nxt = hold_r;
      end else begin
        src = last_r;
      end
      ins_nxt = ~ready_r;
      del_nxt = del_pend_r;
      out_cnt_nxt = 4'h0;
    end
    out_sr_nxt = src;
    pcm_nxt = pcm_r;
    if (!pins.slot_env) begin
      pcm_nxt = 1'b1;
    end else if (lclk_rise && out_cnt_nxt != cdslc_pkg::OUT_BITS_CNT) begin
      pcm_nxt = src[7];
      out_sr_nxt = {src[6:0], 1'b1};
      out_cnt_nxt = out_cnt_nxt + 4'h1;
    end
  end

  // Transmit line coder
  logic [1:0] ui_r, ui_nxt;
  logic [2:0] tx_idx_r, tx_idx_nxt;
  logic [7:0] tx_word_r, tx_word_nxt;
  logic pol_r, pol_nxt;
  logic pos_n_r, pos_n_nxt;
  logic neg_n_r, neg_n_nxt;
  logic [7:0] tx_data_r, tx_data_nxt;
  logic blk_next;
  logic tx_load;
  logic cur_bit;
  logic sym;

  always_comb begin
    ui_nxt = ui_r;
    tx_idx_nxt = tx_idx_r;
    tx_word_nxt = tx_word_r;
    pol_nxt = pol_r;
    pos_n_nxt = pos_n_r;
    neg_n_nxt = neg_n_r;
    blk_next = ui_tick & (ui_r == cdslc_pkg::LAST_UI_IDX);
    tx_load = blk_next & (tx_idx_r == cdslc_pkg::LAST_BIT_IDX);
    cur_bit = tx_word_r[3'h7 - tx_idx_r];
    sym = cur_bit ? ~ui_r[1] : ~ui_r[0];
    if (ui_tick) begin
      ui_nxt = ui_r + 2'h1;
      pos_n_nxt = ~(sym == pol_r);
      neg_n_nxt = (sym == pol_r);
    end
    if (blk_next) begin
      tx_idx_nxt = tx_idx_r + 3'h1;
      if (tx_idx_r == cdslc_pkg::PRE_LAST_BIT_IDX &&
          !pins.alarm_req) begin
        pol_nxt = pol_r;
      end else begin
        pol_nxt = ~pol_r;
      end
    end
    if (tx_load) begin
      tx_word_nxt = tx_data_r;
    end
  end

  // Register slave, status and interrupt
  cdslc_pkg::cdslc_evt_t status_r, status_nxt;
  cdslc_pkg::cdslc_evt_t mask_r, mask_nxt;
  cdslc_pkg::cdslc_evt_t evt;
  logic [31:0] rdata_nxt, rdata_nxt_r;
  logic alarm_nxt;
  logic alarm_r;

  always_comb begin
    alarm_nxt = (miss_nxt == cdslc_pkg::MISS_LIMIT_CNT);
    evt.ins = slot_start & ~ready_r;
    evt.del = overwrite;
    evt.alarm = alarm_nxt & ~alarm_r;
    evt.tx_load = tx_load;
    status_nxt = status_r;
    mask_nxt = mask_r;
    tx_data_nxt = tx_data_r;
    rdata_nxt = 32'h0;
    if (i_bus.wr) begin
      if (i_bus.addr == cdslc_pkg::ADDR_STATUS) begin
        status_nxt = status_r & ~i_bus.wdata[3:0];
      end else if (i_bus.addr == cdslc_pkg::ADDR_MASK) begin
        mask_nxt = i_bus.wdata[3:0];
      end else if (i_bus.addr == cdslc_pkg::ADDR_TX_DATA) begin
        tx_data_nxt = i_bus.wdata[7:0];
      end
    end
    // Hardware set wins over a clear in the same cycle
    status_nxt = status_nxt | evt;
    if (i_bus.rd) begin
      if (i_bus.addr == cdslc_pkg::ADDR_STATUS) begin
        rdata_nxt = {28'h0, status_r};
      end else if (i_bus.addr == cdslc_pkg::ADDR_MASK) begin
        rdata_nxt = {28'h0, mask_r};
      end else if (i_bus.addr == cdslc_pkg::ADDR_TX_DATA) begin
        rdata_nxt = {24'h0, tx_data_r};
      end else if (i_bus.addr == cdslc_pkg::ADDR_STATE) begin
        rdata_nxt = {21'h0, alarm_r, del_r, ins_r, last_r};
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pins_d_r <= '0;
      fill_r <= cdslc_pkg::OCTET_RESET;
      rx_idx_r <= 3'h0;
      miss_r <= 4'h0;
      hold_r <= cdslc_pkg::OCTET_RESET;
      ready_r <= 1'b0;
      del_pend_r <= 1'b0;
      out_sr_r <= cdslc_pkg::OCTET_RESET;
      last_r <= cdslc_pkg::OCTET_RESET;
      out_cnt_r <= 4'h0;
      pcm_r <= 1'b1;
      ins_r <= 1'b0;
      del_r <= 1'b0;
      ui_r <= 2'h0;
      tx_idx_r <= 3'h0;
      tx_word_r <= cdslc_pkg::TX_DATA_RESET;
      pol_r <= 1'b1;
      pos_n_r <= 1'b1;
      neg_n_r <= 1'b1;
      tx_data_r <= cdslc_pkg::TX_DATA_RESET;
      status_r <= cdslc_pkg::STATUS_RESET;
      mask_r <= cdslc_pkg::MASK_RESET;
      rdata_nxt_r <= 32'h0;
      alarm_r <= 1'b0;
    end else begin
      pins_d_r <= pins;
      fill_r <= fill_nxt;
      rx_idx_r <= rx_idx_nxt;
      miss_r <= miss_nxt;
      hold_r <= hold_nxt;
      ready_r <= ready_nxt;
      del_pend_r <= del_pend_nxt;
      out_sr_r <= out_sr_nxt;
      last_r <= last_nxt;
      out_cnt_r <= out_cnt_nxt;
      pcm_r <= pcm_nxt;
      ins_r <= ins_nxt;
      del_r <= del_nxt;
      ui_r <= ui_nxt;
      tx_idx_r <= tx_idx_nxt;
      tx_word_r <= tx_word_nxt;
      pol_r <= pol_nxt;
      pos_n_r <= pos_n_nxt;
      neg_n_r <= neg_n_nxt;
      tx_data_r <= tx_data_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      rdata_nxt_r <= rdata_nxt;
      alarm_r <= alarm_nxt;
    end
  end

  assign o_rdata = rdata_nxt_r;
  assign o_pcm_serial_output = pcm_r;
  assign o_receive_byte_inserted_flag = ins_r;
  assign o_receive_byte_deleted_flag = del_r;
  assign o_octet_alarm = alarm_r;
  assign o_tx_pos_n = pos_n_r;
  assign o_tx_neg_n = neg_n_r;
  assign o_irq = |(status_r & mask_r);

  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  sequence s_pend_taken;
    del_pend_r && slot_start;
  endsequence

  rails_exclusive_a: assert property (!(!o_tx_pos_n && !o_tx_neg_n))
    else $error("both transmit rails marked");
  block_alternate_a: assert property (
    blk_next && tx_idx_r != cdslc_pkg::PRE_LAST_BIT_IDX
    |=> pol_r != $past(pol_r))
    else $error("block polarity did not alternate");
  octet_violation_a: assert property (
    blk_next && tx_idx_r == cdslc_pkg::PRE_LAST_BIT_IDX && !pins.alarm_req
    |=> pol_r == $past(pol_r) && tx_idx_r == cdslc_pkg::LAST_BIT_IDX)
    else $error("eighth block did not repeat polarity");
  alarm_no_viol_a: assert property (
    blk_next && tx_idx_r == cdslc_pkg::PRE_LAST_BIT_IDX && pins.alarm_req
    |=> pol_r != $past(pol_r))
    else $error("violation inserted during alarm request");
  symbol_pattern_a: assert property (
    ui_tick && ui_r == 2'h1 && cur_bit
    |=> (o_tx_pos_n == !pol_r) ##0 $stable(pol_r))
    else $error("one block second symbol wrong");
  viol_clears_alarm_a: assert property (
    rx_rise && pins.rx_viol |=> !o_octet_alarm ##1 !o_octet_alarm)
    else $error("alarm high after received violation");
  insert_flag_a: assert property (
    slot_start && !ready_r |=> o_receive_byte_inserted_flag
    && last_r == $past(last_r))
    else $error("repeat slot without inserted flag");
  normal_slot_a: assert property (
    slot_start && ready_r && !del_pend_r
    |=> !o_receive_byte_inserted_flag && !o_receive_byte_deleted_flag)
    else $error("slip flag left high in normal slot");
  discard_pend_a: assert property (overwrite |=> del_pend_r)
    else $error("discarded octet not remembered");
  delete_flag_a: assert property (
    s_pend_taken |=> o_receive_byte_deleted_flag)
    else $error("discarded octet not flagged");
  pcm_idle_a: assert property (
    !pins.slot_env |=> o_pcm_serial_output ##1 o_pcm_serial_output
    || pins.slot_env)
    else $error("serial output not idle outside slot");
endmodule : cdslc_top

// ---- include/cdslc_pkg.sv ----
// Shared constants and types of the codirectional slip and line coding block
package cdslc_pkg;
  // Line code geometry
  localparam int OCTET_BITS = 8;
  localparam int UI_PER_BIT = 4;
  localparam int MISS_LIMIT = 8;
  localparam logic [2:0] LAST_BIT_IDX = 3'h7;
  localparam logic [2:0] PRE_LAST_BIT_IDX = 3'h6;
  localparam logic [1:0] LAST_UI_IDX = 2'h3;
  localparam logic [3:0] MISS_LIMIT_CNT = 4'h8;
  localparam logic [3:0] OUT_BITS_CNT = 4'h8;

  // Register map, byte addresses
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_MASK = 4'h4;
  localparam logic [3:0] ADDR_TX_DATA = 4'h8;
  localparam logic [3:0] ADDR_STATE = 4'hc;

  // Reset values
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [7:0] TX_DATA_RESET = 8'hff;
  localparam logic [7:0] OCTET_RESET = 8'hff;

  // Status and mask layout, high bit first
  typedef struct packed {
    logic tx_load;
    logic alarm;
    logic del;
    logic ins;
  } cdslc_evt_t;

  // Register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } cdslc_bus_req_t;

  // Synchronised pin bundle
  typedef struct packed {
    logic lclk;
    logic slot_env;
    logic rx_clk;
    logic rx_data;
    logic rx_viol;
    logic ui_clk;
    logic alarm_req;
  } cdslc_pins_t;
endpackage : cdslc_pkg

// ---- test/cdslc_line_model.sv ----
// Line side model: recovered bit clock, decoded bit, violation marker
`timescale 1ns/100ps
module cdslc_line_model (
  input wire logic i_clk_sys,
  output logic o_bit_clk,
  output logic o_bit_data,
  output logic o_bit_viol
);
  initial begin
    o_bit_clk = 1'b0;
    o_bit_data = 1'b0;
    o_bit_viol = 1'b0;
  end

  // One octet MSB first; half sets the pace, clock idle low afterwards
  task automatic send_octet(input logic [7:0] oct, input logic mark,
                            input int half);
    for (int i = 7; i >= 0; i--) begin
      @(posedge i_clk_sys);
      o_bit_data <= oct[i];
      o_bit_viol <= mark && (i == 0);
      repeat (half) @(posedge i_clk_sys);
      o_bit_clk <= 1'b1;
      repeat (half) @(posedge i_clk_sys);
      o_bit_clk <= 1'b0;
    end
    // Released line shows the inverse, never the last value
    o_bit_data <= ~oct[0];
    o_bit_viol <= 1'b0;
  endtask : send_octet
endmodule : cdslc_line_model

// ---- test/tb_codirectional_slip_and_line_coding.sv ----
// Self-checking bench for the slip control and line coder
`timescale 1ns/100ps
module tb_codirectional_slip_and_line_coding;
  logic i_clk_sys;
  logic i_rst_n;
  logic lclk;
  logic env;
  logic ui_clk;
  logic alarm_req;
  cdslc_pkg::cdslc_bus_req_t bus;
  logic bit_clk;
  logic bit_data;
  logic bit_viol;
  logic [31:0] rdata;
  logic pcm;
  logic ins_flag;
  logic del_flag;
  logic oct_alarm;
  logic pos_n;
  logic neg_n;
  logic irq;
  logic [31:0] rv;
  int err_total;
  int comparisons;

  cdslc_top cdslc_top_inst (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_local_receive_bit_clock(lclk),
    .i_rx_slot_env(env),
    .i_rx_bit_clk(bit_clk),
    .i_rx_bit_data(bit_data),
    .i_rx_bit_viol(bit_viol),
    .i_tx_ui_clk(ui_clk),
    .i_transmit_alarm_request(alarm_req),
    .i_bus(bus),
    .o_rdata(rdata),
    .o_pcm_serial_output(pcm),
    .o_receive_byte_inserted_flag(ins_flag),
    .o_receive_byte_deleted_flag(del_flag),
    .o_octet_alarm(oct_alarm),
    .o_tx_pos_n(pos_n),
    .o_tx_neg_n(neg_n),
    .o_irq(irq)
  );

  cdslc_line_model cdslc_line_model_inst (
    .i_clk_sys(i_clk_sys),
    .o_bit_clk(bit_clk),
    .o_bit_data(bit_data),
    .o_bit_viol(bit_viol)
  );

  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    comparisons++;
    if (got !== exp) begin
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
      err_total++;
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge i_clk_sys);
    bus.wr <= 1'b0;
    @(posedge i_clk_sys);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge i_clk_sys);
    bus.rd <= 1'b0;
    @(negedge i_clk_sys);
    d = rdata;
    @(posedge i_clk_sys);
  endtask : rd

  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
    rd(a, rv);
    chk(rv, exp, "register");
  endtask : rdchk

  task automatic pinchk(input logic got, input logic exp, input string m);
    @(negedge i_clk_sys);
    chk({31'h0, got}, {31'h0, exp}, m);
    @(posedge i_clk_sys);
  endtask : pinchk

  // One receive slot: eight local clock pulses inside the envelope
  task automatic slot(input logic [7:0] oct, input logic ins,
                      input logic del);
    env <= 1'b1;
    for (int i = 7; i >= 0; i--) begin
      lclk <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
      lclk <= 1'b0;
      repeat (3) @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      chk({29'h0, pcm, ins_flag, del_flag}, {29'h0, oct[i], ins, del},
          "slot bit");
      @(posedge i_clk_sys);
    end
    env <= 1'b0;
    repeat (12) @(posedge i_clk_sys);
    pinchk(pcm, 1'b1, "idle pcm");
  endtask : slot

  task automatic tick(output logic p);
    ui_clk <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    ui_clk <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    p = pos_n;
    chk({31'h0, neg_n}, {31'h0, ~pos_n}, "rails");
    @(posedge i_clk_sys);
  endtask : tick

  // One transmitted octet, checked symbol by symbol from its start
  task automatic txo(input logic [7:0] d, input logic al);
    logic p;
    logic [31:0] pos;
    logic pol;
    logic s;
    int k;
    alarm_req <= al;
    wr(cdslc_pkg::ADDR_TX_DATA, {24'h0, d});
    wr(cdslc_pkg::ADDR_STATUS, 32'h8);
    k = 0;
    rv = 32'h0;
    while (rv[3] !== 1'b1) begin
      if (k == 40) begin
        err_total++;
        $display("ERROR %0t no transmit load", $time);
        conclude();
      end
      tick(p);
      rd(cdslc_pkg::ADDR_STATUS, rv);
      k++;
    end
    for (int i = 0; i < 32; i++) tick(pos[i]);
    pol = ~pos[0];
    for (int i = 0; i < 32; i++) begin
      if (i % 4 == 0 && i > 0 && !(i == 28 && !al)) pol = ~pol;
      s = d[7 - i / 4] ? (i % 4 < 2) : (i % 2 == 0);
      chk({31'h0, pos[i]}, {31'h0, s ^ pol}, "symbol");
    end
  endtask : txo

  initial begin
    err_total = 0;
    comparisons = 0;
    i_rst_n = 1'b0;
    lclk = 1'b0;
    env = 1'b0;
    ui_clk = 1'b0;
    alarm_req = 1'b0;
    bus = '0;
    repeat (6) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    @(posedge i_clk_sys);
    pinchk(pcm, 1'b1, "reset pcm");
    rdchk(cdslc_pkg::ADDR_TX_DATA, 32'hff);
    rdchk(cdslc_pkg::ADDR_MASK, 32'h0);
    rdchk(cdslc_pkg::ADDR_STATUS, 32'h0);
    $display("reset test done");
    cdslc_line_model_inst.send_octet(8'ha5, 1'b1, 10);
    slot(8'ha5, 1'b0, 1'b0);
    slot(8'ha5, 1'b1, 1'b0);
    cdslc_line_model_inst.send_octet(8'h3c, 1'b1, 16);
    cdslc_line_model_inst.send_octet(8'hc3, 1'b1, 10);
    slot(8'hc3, 1'b0, 1'b1);
    cdslc_line_model_inst.send_octet(8'h96, 1'b1, 10);
    slot(8'h96, 1'b0, 1'b0);
    $display("slip test done");
    rdchk(cdslc_pkg::ADDR_STATUS, 32'h3);
    rdchk(cdslc_pkg::ADDR_STATE, 32'h96);
    wr(cdslc_pkg::ADDR_MASK, 32'h1);
    pinchk(irq, 1'b1, "irq on");
    wr(cdslc_pkg::ADDR_STATUS, 32'h1);
    pinchk(irq, 1'b0, "irq off");
    rdchk(cdslc_pkg::ADDR_STATUS, 32'h2);
    wr(4'h3, 32'hf);
    rdchk(4'h3, 32'h0);
    rdchk(cdslc_pkg::ADDR_MASK, 32'h1);
    wr(cdslc_pkg::ADDR_STATUS, 32'h2);
    rdchk(cdslc_pkg::ADDR_STATUS, 32'h0);
    $display("register test done");
    for (int i = 0; i < 7; i++) begin
      cdslc_line_model_inst.send_octet(8'h55, 1'b0, 10);
    end
    pinchk(oct_alarm, 1'b0, "alarm early");
    cdslc_line_model_inst.send_octet(8'h55, 1'b0, 10);
    repeat (10) @(posedge i_clk_sys);
    pinchk(oct_alarm, 1'b1, "alarm");
    rdchk(cdslc_pkg::ADDR_STATUS, 32'h6);
    $display("alarm test done");
    txo(8'h4b, 1'b0);
    txo(8'hb2, 1'b1);
    alarm_req <= 1'b0;
    $display("transmit test done");
    conclude();
  end
endmodule : tb_codirectional_slip_and_line_coding
